// [spist_top.sv]
// Functional notes
// - status bits 28:24 give receive element count, enhanced mode meaning
// - status bits 20:16 give transmit element count, enhanced mode meaning
// - bit 12 frame error set by hardware in framed mode, software clears
// - bit 11 high while the shifter is active or transmit data waits in the buffer, low otherwise
// - bit 8 underrun set in framed mode, cleared only by module disable
// - bit 7 shows shift register empty, enhanced mode meaning
// - word arriving while receive buffer full is dropped, bit 6 set
// - bit 5 high when cpu read pointer equals serial write pointer
// - bit 3 set on transmit move to shifter, cleared on data write
// - standard mode bit 1 set by data write, cleared on move out
// - enhanced mode bit 1 high when cpu write pointer plus one hits read
// - standard mode bit 0 set on receive move, cleared on data read
// - enhanced mode bit 0 high when serial write pointer plus one hits read
// - unimplemented status bits read as zero
// - error event raised only when matching event enable is set
// - tolerated overflow keeps fifo data, otherwise overflow stops module
// - tolerated underrun sends zeros, otherwise underrun stops module
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps

module spist_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // filling side
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   // draining side
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [WIDTH-1:0]                out_data_o,
   // pointers and fill level
   output logic [$clog2(DEPTH)-1:0]        wptr_o,
   output logic [$clog2(DEPTH)-1:0]        rptr_o,
   output logic [$clog2(DEPTH)-1:0]        count_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
   } spist_fifo_st_t;

   spist_fifo_st_t fifo_reg;
   spist_fifo_st_t fifo_next;

   // one slot kept free so that full and empty differ by pointers alone
   assign in_ready_o  = AW'(fifo_reg.wp + 1'b1) != fifo_reg.rp;
   assign out_valid_o = fifo_reg.wp != fifo_reg.rp;
   assign out_data_o  = fifo_reg.mem[fifo_reg.rp];
   assign wptr_o      = fifo_reg.wp;
   assign rptr_o      = fifo_reg.rp;
   assign count_o     = AW'(fifo_reg.wp - fifo_reg.rp);

   always_comb begin
      fifo_next = fifo_reg;
      if (in_valid_i && in_ready_o) begin
         fifo_next.mem[fifo_reg.wp] = in_data_i;
         fifo_next.wp               = AW'(fifo_reg.wp + 1'b1);
      end
      if (out_valid_o && out_ready_i) begin
         fifo_next.rp = AW'(fifo_reg.rp + 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end

endmodule

module spist_top
   import spist_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [DATA_W-1:0] dat_i,
   output logic [DATA_W-1:0]      dat_o,
   output logic                   ack_o,
   // shift register side, same clock
   output logic                   ser_enable_o,
   input  wire logic              ser_tx_req_i,
   output logic                   ser_tx_valid_o,
   output logic [DATA_W-1:0]      ser_tx_data_o,
   input  wire logic              ser_rx_valid_i,
   output logic                   ser_rx_ready_o,
   input  wire logic [DATA_W-1:0] ser_rx_data_i,
   input  wire logic              ser_frame_err_i,
   input  wire logic              ser_active_i,
   // error event
   output logic                   error_event_o
);

   spist_state_t st_reg;
   spist_state_t st_next;

   logic              req;
   logic              wr;
   logic              rd;
   logic              a_st;
   logic              a_ct;
   logic              a_dat;
   logic              run;
   logic              tx_ok;
   logic              rx_ok;
   logic              tx_in_valid;
   logic              tx_in_ready;
   logic              tx_out_valid;
   logic [DATA_W-1:0] tx_head;
   logic [PTR_W-1:0]  tx_wptr;
   logic [PTR_W-1:0]  tx_rptr;
   logic [PTR_W-1:0]  tx_cnt;
   logic              rx_in_valid;
   logic              rx_in_ready;
   logic              rx_out_valid;
   logic [DATA_W-1:0] rx_head;
   logic [PTR_W-1:0]  rx_wptr;
   logic [PTR_W-1:0]  rx_rptr;
   logic [PTR_W-1:0]  rx_cnt;
   logic              cpu_push;
   logic              cpu_pop;
   logic              tx_pop;
   logic              underrun;
   logic              rx_take;
   logic              overflow;
   logic              frame_set;
   logic              evt_now;
   logic [31:0]       status_w;
   logic [31:0]       ctrl_w;

   function automatic logic ptr_hits(input logic [PTR_W-1:0] a,
                                     input logic [PTR_W-1:0] b);
      return PTR_W'(a + 1'b1) == b;
   endfunction

   // bus request decode
   assign req   = cyc_i && stb_i && !st_reg.ack;
   assign wr    = req && we_i;
   assign rd    = req && !we_i;
   assign a_st  = adr_i == STATUS_OFS;
   assign a_ct  = adr_i == CONTROL_OFS;
   assign a_dat = adr_i == DATA_OFS;
   assign run   = st_reg.ctrl.on && !st_reg.halted;

   // standard mode holds a single word per direction
   assign tx_ok = st_reg.ctrl.enhanced_buffer_select || tx_cnt == '0;
   assign rx_ok = st_reg.ctrl.enhanced_buffer_select || rx_cnt == '0;

   assign tx_in_valid = wr && a_dat && (|sel_i) && tx_ok;
   assign cpu_push    = tx_in_valid && tx_in_ready;
   assign cpu_pop     = rd && a_dat && rx_out_valid;
   assign tx_pop      = run && ser_tx_req_i && tx_out_valid;
   assign underrun    = run && ser_tx_req_i && !tx_out_valid &&
                        st_reg.ctrl.framed_mode_enable;
   assign rx_in_valid = run && ser_rx_valid_i && rx_ok;
   assign rx_take     = rx_in_valid && rx_in_ready;
   assign overflow    = run && ser_rx_valid_i && !(rx_ok && rx_in_ready);
   assign frame_set   = run && st_reg.ctrl.framed_mode_enable &&
                        ser_frame_err_i;

   spist_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (tx_in_valid),
      .in_ready_o  (tx_in_ready),
      .in_data_i   (dat_i),
      .out_valid_o (tx_out_valid),
      .out_ready_i (tx_pop),
      .out_data_o  (tx_head),
      .wptr_o      (tx_wptr),
      .rptr_o      (tx_rptr),
      .count_o     (tx_cnt)
   );

   spist_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (rx_in_valid),
      .in_ready_o  (rx_in_ready),
      .in_data_i   (ser_rx_data_i),
      .out_valid_o (rx_out_valid),
      .out_ready_i (cpu_pop),
      .out_data_o  (rx_head),
      .wptr_o      (rx_wptr),
      .rptr_o      (rx_rptr),
      .count_o     (rx_cnt)
   );

   // serial side outputs
   assign ser_enable_o   = run;
   assign ser_tx_valid_o = run && tx_out_valid;
   assign ser_tx_data_o  = tx_out_valid ? tx_head : '0;
   assign ser_rx_ready_o = run && rx_ok && rx_in_ready;

   // bus and event outputs
   assign dat_o         = st_reg.rdata;
   assign ack_o         = st_reg.ack;
   assign error_event_o = st_reg.evt;

   assign evt_now =
      (overflow && st_reg.ctrl.overflow_event_enable) ||
      (underrun && st_reg.ctrl.underrun_event_enable) ||
      (frame_set && st_reg.ctrl.frame_error_event_enable);

   // status word assembly
   always_comb begin
      status_w = '0;
      status_w[ST_RXCNT_LSB +: CNT_W] = CNT_W'(rx_cnt);
      status_w[ST_TXCNT_LSB +: CNT_W] = CNT_W'(tx_cnt);
      status_w[ST_FRAME_ERROR_FLAG] = st_reg.frame_error_flag;
      status_w[ST_BUSY]   = ser_active_i || tx_out_valid;
      status_w[ST_TUR]    = st_reg.tx_underrun_flag;
      status_w[ST_SHIFTER_EMPTY_FLAG]   = !ser_active_i;
      status_w[ST_ROV]    = st_reg.rx_overflow_flag;
      status_w[ST_RBE]    = rx_rptr == rx_wptr;
      status_w[ST_TBE]    = st_reg.tx_buffer_empty_flag;
      status_w[ST_TBF]    = st_reg.ctrl.enhanced_buffer_select ?
                            ptr_hits(tx_wptr, tx_rptr) : tx_cnt != '0;
      status_w[ST_RBF]    = st_reg.ctrl.enhanced_buffer_select ?
                            ptr_hits(rx_wptr, rx_rptr) : rx_cnt != '0;
   end

   always_comb begin
      ctrl_w            = '0;
      ctrl_w[CT_ON]     = st_reg.ctrl.on;
      ctrl_w[CT_ENH]    = st_reg.ctrl.enhanced_buffer_select;
      ctrl_w[CT_FRM]    = st_reg.ctrl.framed_mode_enable;
      ctrl_w[CT_TOLTUR] = st_reg.ctrl.underrun_tolerate;
      ctrl_w[CT_TOLROV] = st_reg.ctrl.overflow_tolerate;
      ctrl_w[CT_TUREN]  = st_reg.ctrl.underrun_event_enable;
      ctrl_w[CT_ROVEN]  = st_reg.ctrl.overflow_event_enable;
      ctrl_w[CT_FEEN]   = st_reg.ctrl.frame_error_event_enable;
   end

   always_comb begin
      st_next           = st_reg;
      st_next.ack       = req;
      st_next.evt       = evt_now;
      st_next.rd_status = rd && a_st;
      if (rd) begin
         if (a_st) begin
            st_next.rdata = status_w;
         end else if (a_ct) begin
            st_next.rdata = ctrl_w;
         end else if (a_dat && rx_out_valid) begin
            st_next.rdata = rx_head;
         end else begin
            st_next.rdata = '0;
         end
      end
      if (wr && a_ct && sel_i[0]) begin
         st_next.ctrl.on                     = dat_i[CT_ON];
         st_next.ctrl.enhanced_buffer_select = dat_i[CT_ENH];
         st_next.ctrl.framed_mode_enable     = dat_i[CT_FRM];
      end
      if (wr && a_ct && sel_i[1]) begin
         st_next.ctrl.underrun_tolerate        = dat_i[CT_TOLTUR];
         st_next.ctrl.overflow_tolerate        = dat_i[CT_TOLROV];
         st_next.ctrl.underrun_event_enable    = dat_i[CT_TUREN];
         st_next.ctrl.overflow_event_enable    = dat_i[CT_ROVEN];
         st_next.ctrl.frame_error_event_enable = dat_i[CT_FEEN];
      end
      if (wr && a_st && sel_i[0] && !dat_i[ST_ROV]) begin
         st_next.rx_overflow_flag = 1'b0;
      end
      if (wr && a_st && sel_i[1] && !dat_i[ST_FRAME_ERROR_FLAG]) begin
         st_next.frame_error_flag = 1'b0;
      end
      if (!st_reg.ctrl.on) begin
         st_next.tx_underrun_flag = 1'b0;
         st_next.halted           = 1'b0;
      end
      if (cpu_push) begin
         st_next.tx_buffer_empty_flag = 1'b0;
      end
      if (tx_pop) begin
         st_next.tx_buffer_empty_flag = 1'b1;
      end
      if (overflow) begin
         st_next.rx_overflow_flag = 1'b1;
      end
      if (frame_set) begin
         st_next.frame_error_flag = 1'b1;
      end
      if (underrun) begin
         st_next.tx_underrun_flag = 1'b1;
      end
      if ((overflow && !st_reg.ctrl.overflow_tolerate) ||
          (underrun && !st_reg.ctrl.underrun_tolerate)) begin
         st_next.halted = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg                      <= '0;
         st_reg.tx_buffer_empty_flag <= TBE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_stopped;
      st_reg.halted && !ser_enable_o;
   endsequence

   sequence s_overflow_hard;
      overflow && !st_reg.ctrl.overflow_tolerate;
   endsequence

   property p_tbe_set;
      tx_pop |=> st_reg.tx_buffer_empty_flag;
   endproperty
   a_tbe_set: assert property (p_tbe_set)
      else $error("tbe not set after move to shifter");

   property p_tbe_clr;
      cpu_push && !tx_pop |=> !status_w[ST_TBE];
   endproperty
   a_tbe_clr: assert property (p_tbe_clr)
      else $error("tbe not cleared after data write");

   property p_tbf_std;
      cpu_push && !st_reg.ctrl.enhanced_buffer_select && !(wr && a_ct)
         |=> status_w[ST_TBF] || $past(tx_pop);
   endproperty
   a_tbf_std: assert property (p_tbf_std)
      else $error("standard tbf not set after write");

   property p_rbf_std;
      rx_take && !st_reg.ctrl.enhanced_buffer_select && !(wr && a_ct)
         |=> status_w[ST_RBF];
   endproperty
   a_rbf_std: assert property (p_rbf_std)
      else $error("standard rbf not set after receive");

   property p_rov;
      overflow && !cpu_pop |=> st_reg.rx_overflow_flag &&
         rx_cnt == $past(rx_cnt);
   endproperty
   a_rov: assert property (p_rov)
      else $error("overflow not flagged or word stored");

   property p_tur_hold;
      st_reg.tx_underrun_flag && st_reg.ctrl.on |=> st_reg.tx_underrun_flag;
   endproperty
   a_tur_hold: assert property (p_tur_hold)
      else $error("underrun cleared while module on");

   property p_fe_set;
      frame_set |=> status_w[ST_FRAME_ERROR_FLAG] ##1 $stable(st_reg.frame_error_flag)
         || $past(wr);
   endproperty
   a_fe_set: assert property (p_fe_set)
      else $error("frame error not flagged");

   property p_evt;
      error_event_o |-> $past(evt_now) && $past(overflow || underrun ||
         frame_set);
   endproperty
   a_evt: assert property (p_evt)
      else $error("error event without enabled cause");

   property p_halt;
      s_overflow_hard |=> s_stopped;
   endproperty
   a_halt: assert property (p_halt)
      else $error("hard overflow did not stop module");

   property p_rsvd;
      ack_o && st_reg.rd_status |-> (dat_o & ST_RSVD_MASK) == '0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved status bits not zero");

   property p_under_zero;
      underrun && st_reg.ctrl.underrun_tolerate &&
         !(overflow && !st_reg.ctrl.overflow_tolerate)
         |-> ser_tx_data_o == '0 ##1 !st_reg.halted;
   endproperty
   a_under_zero: assert property (p_under_zero)
      else $error("tolerated underrun not sending zeros");

   property p_busy;
      ser_active_i |-> status_w[ST_BUSY] && !status_w[ST_SHIFTER_EMPTY_FLAG];
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not shown while shifter active");

endmodule

// [spist_pkg.sv]
package spist_pkg;

   // data path sizes
   localparam int DATA_W     = 32;
   localparam int FIFO_DEPTH = 4;
   localparam int PTR_W      = $clog2(FIFO_DEPTH);
   localparam int CNT_W      = 5;

   // register byte offsets
   localparam logic [7:0] STATUS_OFS  = 8'h00;
   localparam logic [7:0] CONTROL_OFS = 8'h04;
   localparam logic [7:0] DATA_OFS    = 8'h08;

   // serial_port_status field positions
   localparam int ST_RXCNT_LSB = 24;
   localparam int ST_TXCNT_LSB = 16;
   localparam int ST_FRAME_ERROR_FLAG    = 12;
   localparam int ST_BUSY      = 11;
   localparam int ST_TUR       = 8;
   localparam int ST_SHIFTER_EMPTY_FLAG      = 7;
   localparam int ST_ROV       = 6;
   localparam int ST_RBE       = 5;
   localparam int ST_TBE       = 3;
   localparam int ST_TBF       = 1;
   localparam int ST_RBF       = 0;
   localparam logic [31:0] ST_RSVD_MASK = 32'hE0E0_E614;

   // control register field positions
   localparam int CT_ON     = 0;
   localparam int CT_ENH    = 1;
   localparam int CT_FRM    = 2;
   localparam int CT_TOLTUR = 8;
   localparam int CT_TOLROV = 9;
   localparam int CT_TUREN  = 10;
   localparam int CT_ROVEN  = 11;
   localparam int CT_FEEN   = 12;

   // reset values
   localparam logic TBE_RST = 1'b1;

   typedef struct packed {
      logic frame_error_event_enable;
      logic overflow_event_enable;
      logic underrun_event_enable;
      logic overflow_tolerate;
      logic underrun_tolerate;
      logic framed_mode_enable;
      logic enhanced_buffer_select;
      logic on;
   } spist_ctrl_t;

   typedef struct packed {
      spist_ctrl_t       ctrl;
      logic              frame_error_flag;
      logic              tx_underrun_flag;
      logic              rx_overflow_flag;
      logic              tx_buffer_empty_flag;
      logic              halted;
      logic              ack;
      logic              evt;
      logic              rd_status;
      logic [DATA_W-1:0] rdata;
   } spist_state_t;

endpackage

// [spist_shifter_model.sv]
`timescale 1ns/1ps

module spist_shifter_model
   import spist_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // block side
   input  wire logic [DATA_W-1:0] tx_data_i,
   // shifter signals
   output logic                   tx_req_o,
   output logic                   rx_valid_o,
   output logic [DATA_W-1:0]      rx_data_o,
   output logic                   frame_err_o,
   output logic                   active_o
);

   initial begin
      tx_req_o    = 1'h0;
      rx_valid_o  = 1'h0;
      rx_data_o   = 32'h0000_0000;
      frame_err_o = 1'h0;
      active_o    = 1'h0;
   end

   // one received word, line inverted once released
   task automatic recv(input logic [DATA_W-1:0] w);
      @(posedge clk_i);
      rx_valid_o <= 1'h1;
      rx_data_o  <= w;
      active_o   <= 1'h1;
      @(posedge clk_i);
      rx_valid_o <= 1'h0;
      rx_data_o  <= ~w;
      active_o   <= 1'h0;
   endtask

   // pull one word after a stall of gap cycles
   task automatic take(input int gap, output logic [DATA_W-1:0] w);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      tx_req_o <= 1'h1;
      active_o <= 1'h1;
      @(posedge clk_i);
      w = tx_data_i;
      tx_req_o <= 1'h0;
      active_o <= 1'h0;
   endtask

   // one frame error pulse, or a quiet cycle when b is low
   task automatic ferr(input logic b);
      @(posedge clk_i);
      frame_err_o <= b;
      @(posedge clk_i);
      frame_err_o <= 1'h0;
   endtask

   // shifter holding data or idle
   task automatic hold(input logic b);
      @(posedge clk_i);
      active_o <= b;
   endtask

endmodule

// [tb_spist_top.sv]
`timescale 1ns/1ps

module tb_spist_top
   import spist_pkg::*;
;
   logic              clk = 1'h0;
   logic              rst = 1'h1;
   logic              cyc = 1'h0;
   logic              stb = 1'h0;
   logic              we  = 1'h0;
   logic [7:0]        adr = 8'h00;
   logic [3:0]        sel = 4'h0;
   logic [DATA_W-1:0] wdat = 32'h0000_0000;
   logic [DATA_W-1:0] rdat, txd, rxd, q, w;
   logic              ack, en, txr, txv, rxv, rxr, fe, act, evt;
   int                fails = 0, num_checks = 0, cyc_cnt = 0;
   int                evt_cnt = 0, evt_exp = 0;

   always #2.5 clk = ~clk;

   spist_top spist_top_i (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .ser_enable_o(en), .ser_tx_req_i(txr), .ser_tx_valid_o(txv),
      .ser_tx_data_o(txd), .ser_rx_valid_i(rxv), .ser_rx_ready_o(rxr),
      .ser_rx_data_i(rxd), .ser_frame_err_i(fe), .ser_active_i(act),
      .error_event_o(evt));

   spist_shifter_model spist_shifter_model_i (
      .clk_i(clk), .tx_data_i(txd), .tx_req_o(txr), .rx_valid_o(rxv),
      .rx_data_o(rxd), .frame_err_o(fe), .active_o(act));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc_cnt++;
      if (evt === 1'h1)
         evt_cnt++;
      if (cyc_cnt == 4000) begin
         fails++;
         $display("unexpected %0t run too long", $time);
         tally_and_finish;
      end
   end

   task automatic chk(input logic [31:0] got, e, input string m);
      num_checks++;
      if (got !== e) begin
         fails++;
         $display("unexpected %0t %s got %h", $time, m, got);
      end
   endtask

   // classic single cycle, held until ack is sampled
   task automatic wb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= wr;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'h0, a, 32'h0000_0000, 4'hF);
      chk(q, e, "read");
   endtask

   task automatic t_reset;
      rd(STATUS_OFS, 32'h0000_00A8);
      rd(CONTROL_OFS, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_std_tx;
      wb(1'h1, CONTROL_OFS, 32'h0000_0001, 4'hF);
      wb(1'h1, DATA_OFS, 32'h1234_5678, 4'hF);
      rd(STATUS_OFS, 32'h0001_08A2);
      chk(txv, 1'h1, "tx valid");
      wb(1'h1, DATA_OFS, 32'hDEAD_0001, 4'hF);
      spist_shifter_model_i.take(2, w);
      chk(w, 32'h1234_5678, "std tx word");
      rd(STATUS_OFS, 32'h0000_00A8);
      chk(txv, 1'h0, "tx drained");
      spist_shifter_model_i.take(0, w);
      rd(STATUS_OFS, 32'h0000_00A8);
      spist_shifter_model_i.hold(1'h1);
      rd(STATUS_OFS, 32'h0000_0828);
      spist_shifter_model_i.hold(1'h0);
      rd(STATUS_OFS, 32'h0000_00A8);
      $display("test std tx done");
   endtask

   task automatic t_std_rx;
      wb(1'h1, CONTROL_OFS, 32'h0000_0801, 4'hF);
      spist_shifter_model_i.recv(32'hAAAA_0001);
      rd(STATUS_OFS, 32'h0100_0089);
      spist_shifter_model_i.recv(32'hBBBB_0002);
      evt_exp++;
      rd(STATUS_OFS, 32'h0100_00C9);
      chk(en, 1'h0, "halt");
      rd(DATA_OFS, 32'hAAAA_0001);
      rd(STATUS_OFS, 32'h0000_00E8);
      wb(1'h1, STATUS_OFS, 32'h0000_0000, 4'h1);
      rd(STATUS_OFS, 32'h0000_00A8);
      wb(1'h1, CONTROL_OFS, 32'h0000_0000, 4'hF);
      wb(1'h1, CONTROL_OFS, 32'h0000_0A01, 4'hF);
      spist_shifter_model_i.recv(32'hCCCC_0003);
      spist_shifter_model_i.recv(32'hDDDD_0004);
      evt_exp++;
      rd(STATUS_OFS, 32'h0100_00C9);
      chk(en, 1'h1, "tolerated");
      rd(DATA_OFS, 32'hCCCC_0003);
      wb(1'h1, STATUS_OFS, 32'h0000_0000, 4'h1);
      rd(STATUS_OFS, 32'h0000_00A8);
      $display("test std rx done");
   endtask

   task automatic t_enh;
      wb(1'h1, CONTROL_OFS, 32'h0000_0003, 4'hF);
      for (int i = 0; i < 4; i++)
         wb(1'h1, DATA_OFS, 32'hC0DE_0000 | i, 4'hF);
      rd(STATUS_OFS, 32'h0003_08A2);
      spist_shifter_model_i.take(3, w);
      chk(w, 32'hC0DE_0000, "enh tx 0");
      rd(STATUS_OFS, 32'h0002_08A8);
      for (int i = 1; i < 3; i++) begin
         spist_shifter_model_i.take(0, w);
         chk(w, 32'hC0DE_0000 | i, "enh tx");
      end
      rd(STATUS_OFS, 32'h0000_00A8);
      for (int i = 0; i < 3; i++)
         spist_shifter_model_i.recv(32'hFEED_0000 | i);
      rd(STATUS_OFS, 32'h0300_0089);
      chk(rxr, 1'h0, "rx ready");
      for (int i = 0; i < 3; i++)
         rd(DATA_OFS, 32'hFEED_0000 | i);
      rd(DATA_OFS, 32'h0000_0000);
      rd(STATUS_OFS, 32'h0000_00A8);
      $display("test enh done");
   endtask

   task automatic t_framed;
      wb(1'h1, CONTROL_OFS, 32'h0000_1405, 4'hF);
      spist_shifter_model_i.ferr(1'h1);
      evt_exp++;
      rd(STATUS_OFS, 32'h0000_10A8);
      wb(1'h1, STATUS_OFS, 32'h0000_0000, 4'h2);
      rd(STATUS_OFS, 32'h0000_00A8);
      spist_shifter_model_i.ferr(1'h0);
      rd(STATUS_OFS, 32'h0000_00A8);
      wb(1'h1, CONTROL_OFS, 32'h0000_0405, 4'hF);
      spist_shifter_model_i.ferr(1'h1);
      rd(STATUS_OFS, 32'h0000_10A8);
      wb(1'h1, STATUS_OFS, 32'h0000_0000, 4'h2);
      spist_shifter_model_i.take(1, w);
      evt_exp++;
      rd(STATUS_OFS, 32'h0000_01A8);
      chk(en, 1'h0, "underrun halt");
      wb(1'h1, STATUS_OFS, 32'h0000_0000, 4'hF);
      rd(STATUS_OFS, 32'h0000_01A8);
      wb(1'h1, CONTROL_OFS, 32'h0000_0000, 4'hF);
      wb(1'h1, CONTROL_OFS, 32'h0000_0105, 4'hF);
      rd(STATUS_OFS, 32'h0000_00A8);
      spist_shifter_model_i.take(0, w);
      chk(w, 32'h0000_0000, "zero fill");
      chk(en, 1'h1, "underrun tolerated");
      rd(STATUS_OFS, 32'h0000_01A8);
      wb(1'h1, CONTROL_OFS, 32'h0000_0000, 4'hF);
      rd(STATUS_OFS, 32'h0000_00A8);
      chk(evt_cnt, evt_exp, "event count");
      $display("test framed done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      t_reset;
      t_std_tx;
      t_std_rx;
      t_enh;
      t_framed;
      tally_and_finish;
   end

endmodule
